// ===== verilog/sensor_config_status_udp_framer.sv
// Query responder and point-cloud UDP framer with output byte FIFO
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic in_valid_in, // Write request
  output logic in_ready_out, // Not full
  input wire logic [WIDTH-1:0] in_data_in, // Write data
  output logic out_valid_out, // Not empty
  input wire logic out_ready_in, // Read accept
  output logic [WIDTH-1:0] out_data_out // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end
endmodule : byte_fifo

// Functional notes
// - Command 0x8 with empty payload returns the configuration record.
// - Config record: IPs, ports, spin, sync, azimuths, clock, sequence, 16 reserved.
// - Own IP resets to 192.168.1.201, netmask to 255.255.255.0.
// - Destination IP resets to broadcast 255.255.255.255.
// - Point-cloud port resets to 2368 and is reported in config record.
// - GPS port resets to 10110; effective only with satellite clock source.
// - Sync enable resets to zero; one locks sync azimuth to pulse-per-second with satellite clock source only.
// - Points pass only between begin and end azimuth; defaults 0 and 36000.
// - Clock source: zero satellite, one precision-time; resets to zero.
// - Sequence enable resets off; one adds sequence field to every packet.
// - Command 0x9 with empty payload returns the status record.
// - Status record starts with uptime seconds then live rotation speed.
// - Then eight four-byte temperatures in 0.01 C, then 16 reserved bytes.
// - Temperature order: base two, emitter, receiver two, upper three.
// - Sequence on: packet 1194 to 1198 bytes, tail 22 to 26.
// - Sequence on: UDP length 0x04B6, followed by two-byte checksum.
// - Header starts broadcast MAC, source MAC, ethertype 0x08 0x00.
// - UDP source port 0x2710, destination port defaulting 0x0940.
// - Twenty-byte IPv4 header follows the ethertype.
// - Sequence field of four bytes appended after existing tail.
// - Sequence counts packets from 1 to 0xFFFFFFFF, least byte first.
module sensor_config_status_udp_framer
  import framer_pkg::*;
#(
  parameter int TICKS_PER_SEC = CLK_HZ,
  parameter logic [47:0] SRC_MAC = 48'h02_00_00_00_00_01 // Arbitrary value
) (
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic cmd_valid_in, // Host query present
  input wire logic [7:0] cmd_code_in, // Query command code
  output logic cmd_ready_out, // Query taken when idle
  input wire logic cfg_we_in, // Configuration write strobe
  input wire logic [3:0] cfg_sel_in, // Configuration field select
  input wire logic [31:0] cfg_data_in, // Field value, low bits used
  input wire logic [15:0] motor_speed_in, // Live rotation speed
  input wire logic temp_we_in, // Temperature write strobe
  input wire logic [2:0] temp_idx_in, // Temperature slot
  input wire logic [31:0] temp_data_in, // Temperature, 0.01 C
  input wire logic pkt_start_in, // Start point-cloud packet
  output logic pkt_ready_out, // Packet start taken when idle and no query present
  input wire logic pay_valid_in, // Packet body byte valid
  input wire logic [7:0] pay_data_in, // Packet body byte
  input wire logic pay_last_in, // Last body byte
  output logic pay_ready_out, // Body byte taken
  input wire logic point_valid_in, // Azimuth sample valid
  input wire logic [15:0] azimuth_in, // Azimuth, 0.01 degree
  output logic point_pass_out, // Sample inside window
  output logic sync_lock_out, // Lock sync azimuth to PPS
  output logic [15:0] sync_azimuth_out, // Sync azimuth
  output logic ptp_select_out, // Clock source is PTP
  output logic gps_port_valid_out, // GPS port in effect
  output logic [15:0] gps_port_out, // GPS destination port
  output logic [15:0] spin_out, // Rotation setpoint
  output logic [31:0] uptime_out, // Uptime seconds
  output logic tx_valid_out, // Output byte valid
  output logic [7:0] tx_data_out, // Output byte
  output logic tx_last_out, // Last byte of message
  output logic tx_is_pkt_out, // Byte belongs to point cloud
  input wire logic tx_ready_in // Output sink ready
);
  state_t state;
  state_t next_state;
  logic [31:0] own_ip;
  logic [31:0] netmask;
  logic [31:0] gateway;
  logic [31:0] dest_ip;
  logic [15:0] pc_port;
  logic [15:0] gps_port;
  logic [15:0] spin;
  logic [7:0] sync_en;
  logic [15:0] sync_az;
  logic [15:0] az_begin;
  logic [15:0] az_end;
  logic [7:0] clk_src;
  logic [7:0] seq_en;
  logic [31:0] temps [8];
  logic [31:0] uptime;
  logic [31:0] uptime_snap;
  logic [31:0] tick;
  logic [31:0] seq_num;
  logic [10:0] idx;
  logic pkt_mode;
  logic fifo_ready;
  logic [FIFO_WIDTH:0] fifo_out;

  // Record images, first byte in the top bits
  wire [CFG_BYTES*8-1:0] cfg_vec = {own_ip, netmask, gateway, dest_ip,
    pc_port, gps_port, spin, sync_en, sync_az, az_begin, az_end, clk_src, seq_en, 128'h0};
  wire [STS_BYTES*8-1:0] sts_vec = {uptime_snap, motor_speed_in, temps[0], temps[1],
    temps[2], temps[3], temps[4], temps[5], temps[6], temps[7], 128'h0};
  wire seq_on = (seq_en == 8'h01);
  wire [15:0] body_len = seq_on ? 16'(PKT_BYTES_ON) : 16'(PKT_BYTES_OFF);
  wire [15:0] udp_len = body_len + UDP_HDR_BYTES;
  wire [15:0] ip_len = udp_len + IP_HDR_BYTES;
  wire [19:0] ip_sum = 20'(IP_VER_TOS) + 20'(ip_len) + 20'(IP_FLAGS) + 20'(IP_TTL_PROTO)
    + 20'(own_ip[31:16]) + 20'(own_ip[15:0]) + 20'(dest_ip[31:16]) + 20'(dest_ip[15:0]);
  wire [16:0] ip_fold = 17'(ip_sum[15:0]) + 17'(ip_sum[19:16]);
  wire [15:0] ip_csum = ~(ip_fold[15:0] + 16'(ip_fold[16]));
  wire [HDR_BYTES*8-1:0] hdr_vec = {48'hFFFF_FFFF_FFFF, SRC_MAC, ETHERTYPE,
    IP_VER_TOS, ip_len, 16'h0000, IP_FLAGS, IP_TTL_PROTO, ip_csum, own_ip, dest_ip,
    SRC_PORT, pc_port, udp_len, 16'h0000};
  wire [7:0] cfg_byte = cfg_vec[(CFG_BYTES-1-int'(idx))*8 +: 8];
  wire [7:0] sts_byte = sts_vec[(STS_BYTES-1-int'(idx))*8 +: 8];
  wire [7:0] hdr_byte = hdr_vec[(HDR_BYTES-1-int'(idx))*8 +: 8];
  wire [7:0] seq_byte = seq_num[int'(idx[1:0])*8 +: 8];

  wire cmd_take = (state == ST_IDLE) && cmd_valid_in &&
    ((cmd_code_in == CMD_CONFIG) || (cmd_code_in == CMD_HEALTH));
  wire pkt_take = (state == ST_IDLE) && !cmd_valid_in && pkt_start_in;
  assign cmd_ready_out = (state == ST_IDLE);
  assign pkt_ready_out = (state == ST_IDLE) && !cmd_valid_in;
  assign pay_ready_out = (state == ST_PAY) && fifo_ready;

  wire cfg_end = (idx == 11'(CFG_BYTES - 1));
  wire sts_end = (idx == 11'(STS_BYTES - 1));
  wire hdr_end = (idx == 11'(HDR_BYTES - 1));
  wire seq_end = (idx == 11'(SEQ_BYTES - 1));
  wire pay_push = pay_valid_in && pay_ready_out;
  wire gen_push = fifo_ready && ((state == ST_CFG) || (state == ST_STS) ||
    (state == ST_HDR) || (state == ST_SEQ));
  wire push = gen_push || pay_push;
  wire [7:0] push_data = (state == ST_CFG) ? cfg_byte :
    (state == ST_STS) ? sts_byte :
    (state == ST_HDR) ? hdr_byte :
    (state == ST_SEQ) ? seq_byte : pay_data_in;
  wire push_last = ((state == ST_CFG) && cfg_end) || ((state == ST_STS) && sts_end) ||
    ((state == ST_PAY) && pay_last_in && !seq_on) || ((state == ST_SEQ) && seq_end);
  wire step_end = push && push_last;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (cmd_take)
          next_state = (cmd_code_in == CMD_CONFIG) ? ST_CFG : ST_STS;
        else if (pkt_take)
          next_state = ST_HDR;
      end
      ST_CFG, ST_STS:
      begin
        if (step_end)
          next_state = ST_IDLE;
      end
      ST_HDR:
      begin
        if (push && hdr_end)
          next_state = ST_PAY;
      end
      ST_PAY:
      begin
        if (pay_push && pay_last_in)
          next_state = seq_on ? ST_SEQ : ST_IDLE;
      end
      ST_SEQ:
      begin
        if (step_end)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  wire idx_clear = (state != next_state);
  wire seq_wrap = (seq_num == 32'hFFFF_FFFF);
  wire sec_tick = (tick == 32'(TICKS_PER_SEC - 1));
  wire cfg_wr_ok = cfg_we_in;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= ST_IDLE;
      idx <= '0;
      pkt_mode <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idx <= idx_clear ? '0 : (push ? idx + 1'b1 : idx);
      if (pkt_take)
        pkt_mode <= 1'b1;
      else if (cmd_take)
        pkt_mode <= 1'b0;
    end
  end

  // Configuration store
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      own_ip <= OWN_IP_RST;
      netmask <= NETMASK_RST;
      gateway <= GATEWAY_RST;
      dest_ip <= DEST_IP_RST;
      pc_port <= PC_PORT_RST;
      gps_port <= GPS_PORT_RST;
      spin <= SPIN_RST;
      sync_en <= 8'h00;
      sync_az <= 16'h0000;
      az_begin <= AZ_BEGIN_RST;
      az_end <= AZ_END_RST;
      clk_src <= CLK_GPS;
      seq_en <= 8'h00;
    end
    else if (cfg_wr_ok)
    begin
      case (cfg_sel_in)
        SEL_OWN_IP: own_ip <= cfg_data_in;
        SEL_NETMASK: netmask <= cfg_data_in;
        SEL_GATEWAY: gateway <= cfg_data_in;
        SEL_DEST_IP: dest_ip <= cfg_data_in;
        SEL_PC_PORT: pc_port <= cfg_data_in[15:0];
        SEL_GPS_PORT: gps_port <= cfg_data_in[15:0];
        SEL_SPIN: spin <= cfg_data_in[15:0];
        SEL_SYNC_EN: sync_en <= cfg_data_in[7:0];
        SEL_SYNC_AZ: sync_az <= cfg_data_in[15:0];
        SEL_AZ_BEGIN: az_begin <= cfg_data_in[15:0];
        SEL_AZ_END: az_end <= cfg_data_in[15:0];
        SEL_CLK_SRC: clk_src <= cfg_data_in[7:0];
        SEL_SEQ_EN: seq_en <= cfg_data_in[7:0];
        default: own_ip <= own_ip;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (temp_we_in)
      temps[temp_idx_in] <= temp_data_in;
  end

  // Uptime, packet sequence and derived controls
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tick <= '0;
      uptime <= '0;
      uptime_snap <= '0;
      seq_num <= 32'h0000_0001;
      point_pass_out <= 1'b0;
    end
    else
    begin
      tick <= sec_tick ? '0 : tick + 1'b1;
      if (sec_tick)
        uptime <= uptime + 1'b1;
      if (cmd_take)
        uptime_snap <= uptime;
      if ((state == ST_SEQ) && step_end)
        seq_num <= seq_wrap ? 32'h0000_0001 : seq_num + 1'b1;
      if (point_valid_in)
        point_pass_out <= (azimuth_in >= az_begin) && (azimuth_in <= az_end);
    end
  end

  assign sync_lock_out = (sync_en == 8'h01) && (clk_src == CLK_GPS);
  assign sync_azimuth_out = sync_az;
  assign ptp_select_out = (clk_src == CLK_PTP);
  assign gps_port_valid_out = (clk_src == CLK_GPS);
  assign gps_port_out = gps_port;
  assign spin_out = spin;
  assign uptime_out = uptime;
  assign tx_data_out = fifo_out[7:0];
  assign tx_last_out = fifo_out[8];

  // Packet flag rides in the FIFO word, so it stays with its own bytes
  assign tx_is_pkt_out = fifo_out[FIFO_WIDTH];

  byte_fifo #(
    .WIDTH(FIFO_WIDTH + 1),
    .DEPTH(FIFO_DEPTH)
  ) out_fifo (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in({pkt_mode, push_last, push_data}),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_data_out(fifo_out)
  );

  config_query_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (cmd_take && cmd_code_in == CMD_CONFIG) |=> (state == ST_CFG) && (idx == 11'h000))
    else $error("config query not started");
  health_query_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (cmd_take && cmd_code_in == CMD_HEALTH) |=> (state == ST_STS))
    else $error("status query not started");
  config_length_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_CFG && push) |-> (push_last == (idx == 11'd46)))
    else $error("config record length wrong");
  status_length_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_STS && push) |-> (push_last == (idx == 11'd53)))
    else $error("status record length wrong");
  reset_defaults_a: assert property (@(posedge clk_sys_in)
    $rose(rstn_in) |-> own_ip == 32'hC0A801C9 && netmask == 32'hFFFFFF00 && dest_ip == 32'hFFFFFFFF)
    else $error("address defaults wrong");
  udp_length_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_HDR && idx == 11'd38) |-> seq_on == (push_data == 8'h04 && hdr_vec[31:16] == 16'h04B6))
    else $error("udp length wrong");
  sequence_step_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_SEQ && step_end && !seq_wrap) |=> seq_num == $past(seq_num) + 32'h1)
    else $error("sequence number not advanced");
  tail_bytes_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_PAY && pay_push && pay_last_in && seq_on) |=> (state == ST_SEQ)[*4])
    else $error("sequence tail too short");
  azimuth_window_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (point_valid_in && azimuth_in > az_end) |=> !point_pass_out)
    else $error("point outside window passed");
  query_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_CFG || state == ST_STS) |-> !pkt_mode)
    else $error("query bytes marked as packet");
endmodule : sensor_config_status_udp_framer

`default_nettype wire

// ===== include/framer_pkg.sv
// Constants for the configuration, status and point-cloud framer
package framer_pkg;
  localparam logic [7:0] CMD_CONFIG = 8'h08;
  localparam logic [7:0] CMD_HEALTH = 8'h09;
  localparam int CFG_BYTES = 47;
  localparam int STS_BYTES = 54;
  localparam int HDR_BYTES = 42;
  localparam int SEQ_BYTES = 4;
  localparam int PKT_BYTES_OFF = 1194;
  localparam int PKT_BYTES_ON = 1198;
  localparam int TAIL_BYTES_OFF = 22;
  localparam int TAIL_BYTES_ON = 26;
  localparam logic [15:0] UDP_HDR_BYTES = 16'h0008;
  localparam logic [15:0] IP_HDR_BYTES = 16'h0014;
  localparam logic [15:0] UDP_LEN_ON = 16'h04B6;
  localparam logic [31:0] OWN_IP_RST = 32'hC0A801C9;
  localparam logic [31:0] NETMASK_RST = 32'hFFFFFF00;
  localparam logic [31:0] GATEWAY_RST = 32'h00000000;
  localparam logic [31:0] DEST_IP_RST = 32'hFFFFFFFF;
  localparam logic [15:0] PC_PORT_RST = 16'h0940;
  localparam logic [15:0] GPS_PORT_RST = 16'h277E;
  localparam logic [15:0] SPIN_RST = 16'h0258;
  localparam logic [15:0] AZ_BEGIN_RST = 16'h0000;
  localparam logic [15:0] AZ_END_RST = 16'h8CA0;
  localparam logic [15:0] SRC_PORT = 16'h2710;
  localparam logic [15:0] ETHERTYPE = 16'h0800;
  localparam logic [15:0] IP_VER_TOS = 16'h4500;
  localparam logic [15:0] IP_FLAGS = 16'h4000;
  localparam logic [15:0] IP_TTL_PROTO = 16'h4011;
  localparam logic [7:0] CLK_GPS = 8'h00;
  localparam logic [7:0] CLK_PTP = 8'h01;
  localparam logic [3:0] SEL_OWN_IP = 4'h0;
  localparam logic [3:0] SEL_NETMASK = 4'h1;
  localparam logic [3:0] SEL_GATEWAY = 4'h2;
  localparam logic [3:0] SEL_DEST_IP = 4'h3;
  localparam logic [3:0] SEL_PC_PORT = 4'h4;
  localparam logic [3:0] SEL_GPS_PORT = 4'h5;
  localparam logic [3:0] SEL_SPIN = 4'h6;
  localparam logic [3:0] SEL_SYNC_EN = 4'h7;
  localparam logic [3:0] SEL_SYNC_AZ = 4'h8;
  localparam logic [3:0] SEL_AZ_BEGIN = 4'h9;
  localparam logic [3:0] SEL_AZ_END = 4'hA;
  localparam logic [3:0] SEL_CLK_SRC = 4'hB;
  localparam logic [3:0] SEL_SEQ_EN = 4'hC;
  localparam int CLK_HZ = 200_000_000;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 9;
  typedef enum logic [2:0] {ST_IDLE, ST_CFG, ST_STS, ST_HDR, ST_PAY, ST_SEQ} state_t;
endpackage : framer_pkg

// ===== verif/host_sink_model.sv
// Host-side sink that collects framer output bytes, stalling at random
`timescale 1ns/1ps
`default_nettype none
module host_sink_model (
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Reset, active low
  input wire logic slow_in, // Stall at random when high
  input wire logic tx_valid_in, // Byte offered
  input wire logic [7:0] tx_data_in, // Byte value
  input wire logic tx_last_in, // Final byte of message
  input wire logic tx_is_pkt_in, // Byte belongs to a packet
  output logic tx_ready_out // Byte accepted
);
  logic [9:0] rx_q[$];
  int seed = 32'h1F2E3D4C;
  initial tx_ready_out = 1'b0;
  // Ready changes only at falling edges
  always @(negedge clk_sys_in)
    tx_ready_out <= rstn_in && (!slow_in || (($random(seed) & 3) == 0));
  always @(posedge clk_sys_in)
    if (rstn_in && tx_valid_in && tx_ready_out)
      rx_q.push_back({tx_is_pkt_in, tx_last_in, tx_data_in});
endmodule : host_sink_model
`default_nettype wire

// ===== verif/tb_sensor_config_status_udp_framer.sv
// Self-checking bench for the query responder and point-cloud framer
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_config_status_udp_framer;
  import framer_pkg::*;
  localparam logic [47:0] MAC = 48'h02_11_22_33_44_55; // Arbitrary value
  localparam int TPS = 10;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cmd_valid_in = 1'b0, cfg_we_in = 1'b0, temp_we_in = 1'b0, pkt_start_in = 1'b0;
  logic pay_valid_in = 1'b0, pay_last_in = 1'b0, point_valid_in = 1'b0, slow = 1'b0;
  logic [7:0] cmd_code_in = 8'h00, pay_data_in = 8'h00;
  logic [3:0] cfg_sel_in = 4'h0;
  logic [2:0] temp_idx_in = 3'h0;
  logic [31:0] cfg_data_in = 32'h0, temp_data_in = 32'h0;
  logic [15:0] motor_speed_in = 16'h0, azimuth_in = 16'h0;
  logic cmd_ready_out, pkt_ready_out, pay_ready_out, point_pass_out, sync_lock_out;
  logic ptp_select_out, gps_port_valid_out, tx_valid_out, tx_last_out, tx_ready_in, tx_is_pkt_out;
  logic [15:0] sync_azimuth_out, gps_port_out, spin_out;
  logic [7:0] tx_data_out;
  int miscompares = 0, checks_done = 0, seed = 32'h2593997d, cyc = 0, take_cyc;
  int wid[13] = '{4, 4, 4, 4, 2, 2, 2, 1, 2, 2, 2, 1, 1};
  logic [31:0] cfg[13], temp[8], up_got, uptime_out, seq = 32'h1;
  logic [7:0] exp_q[$];

  sensor_config_status_udp_framer #(.TICKS_PER_SEC(TPS), .SRC_MAC(MAC)) u_sensor_config_status_udp_framer (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
    .cmd_ready_out(cmd_ready_out), .cfg_we_in(cfg_we_in), .cfg_sel_in(cfg_sel_in), .cfg_data_in(cfg_data_in),
    .motor_speed_in(motor_speed_in), .temp_we_in(temp_we_in), .temp_idx_in(temp_idx_in),
    .temp_data_in(temp_data_in), .pkt_start_in(pkt_start_in), .pkt_ready_out(pkt_ready_out),
    .pay_valid_in(pay_valid_in), .pay_data_in(pay_data_in), .pay_last_in(pay_last_in),
    .pay_ready_out(pay_ready_out), .point_valid_in(point_valid_in), .azimuth_in(azimuth_in),
    .point_pass_out(point_pass_out), .sync_lock_out(sync_lock_out), .sync_azimuth_out(sync_azimuth_out),
    .ptp_select_out(ptp_select_out), .gps_port_valid_out(gps_port_valid_out), .gps_port_out(gps_port_out),
    .spin_out(spin_out), .uptime_out(uptime_out), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
    .tx_last_out(tx_last_out), .tx_is_pkt_out(tx_is_pkt_out), .tx_ready_in(tx_ready_in));

  host_sink_model u_host_sink_model (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .slow_in(slow),
    .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_last_in(tx_last_out),
    .tx_is_pkt_in(tx_is_pkt_out), .tx_ready_out(tx_ready_in));

  always #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
    cyc <= rstn_in ? cyc + 1 : 0;

  task automatic complete_run();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // Holds the request until the selected ready is seen before a rising edge
  task automatic hold_until(input int k);
    int n;
    for (n = 0; n < 2000; n++)
    begin
      #1;
      if ((k == 0 && cmd_ready_out === 1'b1) || (k == 1 && pkt_ready_out === 1'b1) || (k == 2 && pay_ready_out === 1'b1))
        break;
      @(negedge clk_sys_in);
    end
    if (n == 2000)
    begin
      miscompares++;
      complete_run();
    end
    @(posedge clk_sys_in);
  endtask : hold_until

  // Compares the collected message; the first skip bytes go to up_got
  task automatic check_msg(input int skip, input logic pkt);
    int i, n;
    logic [9:0] got;
    n = exp_q.size();
    for (i = 0; i < 20000 && u_host_sink_model.rx_q.size() < n; i++)
      @(posedge clk_sys_in);
    if (i == 20000)
    begin
      miscompares++;
      complete_run();
    end
    for (i = 0; i < n; i++)
    begin
      got = u_host_sink_model.rx_q.pop_front();
      if (i < skip)
        up_got = {up_got[23:0], got[7:0]};
      else
        check_val({22'h0, got}, {22'h0, pkt, i == n - 1, exp_q[i]});
    end
    exp_q.delete();
  endtask : check_msg

  function automatic void put(input logic [31:0] v, input int nb);
    for (int b = nb - 1; b >= 0; b--)
      exp_q.push_back(v[8*b +: 8]);
  endfunction : put

  function automatic void exp_cfg();
    for (int s = 0; s < 13; s++)
      put(cfg[s], wid[s]);
    put(32'h0, 4);
    put(32'h0, 4);
    put(32'h0, 4);
    put(32'h0, 4);
  endfunction : exp_cfg

  function automatic logic [15:0] ip_sum(input logic [15:0] iplen);
    logic [31:0] s;
    s = 32'h4500 + iplen + 32'h4000 + 32'h4011 + cfg[0][31:16] + cfg[0][15:0] + cfg[3][31:16] + cfg[3][15:0];
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    return ~s[15:0];
  endfunction : ip_sum

  function automatic logic [31:0] rnd_field(input int s);
    if (wid[s] == 1)
      return $random(seed) & 1;
    if (s == 9)
      return {$random(seed)} % 17999 + 1;
    if (s == 10)
      return {$random(seed)} % 18001 + 18000;
    return wid[s] == 2 ? $random(seed) & 32'hFFFF : $random(seed);
  endfunction : rnd_field

  task automatic send_cmd(input logic [7:0] code);
    @(negedge clk_sys_in);
    cmd_valid_in = 1'b1;
    cmd_code_in = code;
    hold_until(0);
    take_cyc = cyc;
    @(negedge clk_sys_in);
    cmd_valid_in = 1'b0;
  endtask : send_cmd

  task automatic wr_cfg(input int s, input logic [31:0] v);
    @(negedge clk_sys_in);
    cfg_we_in = 1'b1;
    cfg_sel_in = s[3:0];
    cfg_data_in = v;
    cfg[s] = v;
    @(negedge clk_sys_in);
    cfg_we_in = 1'b0;
    check_val({gps_port_valid_out, ptp_select_out, sync_lock_out}, {~cfg[11][0], cfg[11][0], cfg[7][0] & ~cfg[11][0]});
    check_val({gps_port_out, spin_out}, {cfg[5][15:0], cfg[6][15:0]});
    check_val(sync_azimuth_out, cfg[8]);
  endtask : wr_cfg

  // One point-cloud packet with a random body, checked byte for byte
  task automatic run_pkt();
    logic [15:0] udplen;
    logic [7:0] d;
    udplen = cfg[12][0] ? 16'h04B6 : 16'h04B2;
    put(32'hFFFFFFFF, 4);
    put({16'hFFFF, MAC[47:32]}, 4);
    put(MAC[31:0], 4);
    put({16'h0800, 16'h4500}, 4);
    put({udplen + 16'h0014, 16'h0000}, 4);
    put({16'h4000, 16'h4011}, 4);
    put({16'h0000, ip_sum(udplen + 16'h0014)}, 2);
    put(cfg[0], 4);
    put(cfg[3], 4);
    put({16'h2710, cfg[4][15:0]}, 4);
    put({udplen, 16'h0000}, 4);
    @(negedge clk_sys_in);
    pkt_start_in = 1'b1;
    hold_until(1);
    @(negedge clk_sys_in);
    pkt_start_in = 1'b0;
    for (int i = 0; i < 1194; i++)
    begin
      d = $random(seed);
      exp_q.push_back(d);
      @(negedge clk_sys_in);
      pay_valid_in = 1'b1;
      pay_data_in = d;
      pay_last_in = (i == 1193);
      hold_until(2);
    end
    @(negedge clk_sys_in);
    pay_valid_in = 1'b0;
    pay_last_in = 1'b0;
    if (cfg[12][0])
    begin
      put({seq[7:0], seq[15:8], seq[23:16], seq[31:24]}, 4);
      seq++;
    end
    check_msg(0, 1'b1);
  endtask : run_pkt

  initial
  begin
    cfg = '{32'hC0A801C9, 32'hFFFFFF00, 32'h0, 32'hFFFFFFFF, 32'h0940, 32'h277E, 32'h0258, 32'h0, 32'h0, 32'h0,
      32'h8CA0, 32'h0, 32'h0};
    repeat (8) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    exp_cfg();
    send_cmd(CMD_CONFIG);
    check_msg(0, 1'b0);
    run_pkt();
    send_cmd(8'h05);
    repeat (20) @(negedge clk_sys_in);
    check_val(u_host_sink_model.rx_q.size(), 0);
    slow = 1'b1;
    for (int s = 0; s < 13; s++)
      wr_cfg(s, rnd_field(s));
    for (int k = 0; k < 4; k++)
    begin
      wr_cfg(7, k & 1);
      wr_cfg(11, k >> 1);
    end
    exp_cfg();
    send_cmd(CMD_CONFIG);
    check_msg(0, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clk_sys_in);
      point_valid_in = 1'b1;
      azimuth_in = k < 4 ? (k[0] ? cfg[9 + k / 2] : cfg[9 + k / 2] + (k < 2 ? -1 : 1)) : $random(seed) % 36001;
      @(negedge clk_sys_in);
      point_valid_in = 1'b0;
      check_val(point_pass_out, azimuth_in >= cfg[9][15:0] && azimuth_in <= cfg[10][15:0]);
    end
    motor_speed_in = $random(seed);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_sys_in);
      temp_we_in = 1'b1;
      temp_idx_in = i[2:0];
      temp_data_in = $random(seed);
      temp[i] = temp_data_in;
      @(negedge clk_sys_in);
      temp_we_in = 1'b0;
    end
    put(32'h0, 4);
    put({16'h0, motor_speed_in}, 2);
    for (int i = 0; i < 8; i++)
      put(temp[i], 4);
    for (int i = 0; i < 4; i++)
      put(32'h0, 4);
    send_cmd(CMD_HEALTH);
    check_msg(4, 1'b0);
    check_val(up_got * TPS + 2 * TPS >= take_cyc && up_got * TPS <= take_cyc + 2 * TPS, 1);
    @(negedge clk_sys_in);
    check_val(uptime_out, cyc / TPS);
    wr_cfg(12, 1);
    run_pkt();
    run_pkt();
    complete_run();
  end
endmodule : tb_sensor_config_status_udp_framer
`default_nettype wire
